// File: settings_handler_regs.svh
// Purpose: Offsets, field positions, reset values and limits of the
//          sensor channel settings handler.
// Assumes: Byte addresses, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef SETTINGS_HANDLER_REGS_SVH
`define SETTINGS_HANDLER_REGS_SVH

// ==========================================================
// Register offsets
`define ADR_VAVG 8'h00
`define ADR_VBW 8'h04
`define ADR_BUFSZ 8'h08
`define ADR_BUFTYPE 8'h0c
`define ADR_GAIN 8'h10
`define ADR_GAIN_ALIAS 8'h14
`define ADR_ERR 8'h18
`define ADR_GAIN_MIN 8'h1c
`define ADR_GAIN_MAX 8'h20

// ==========================================================
// Field positions of the error register
`define ERR_CODE_MSB 15
`define ERR_UPPER_BIT 16
`define ERR_STICKY_BIT 17

// ==========================================================
// Reset values and limits
`define RST_VAVG 1'b1
`define RST_BUFSZ 12'h001
`define BUFSZ_MIN 12'h001
`define BUFSZ_MAX_DEF 2048
`define RST_GAIN 8'h64
`define GAIN_MIN 8'h01
`define GAIN_MAX 8'h96
`define GAIN_SCALE 8'h64

// ==========================================================
// Error codes, two's complement
`define ERR_HW_MISSING 16'hff0f
`define ERR_CONFLICT 16'hff23
`define ERR_RANGE 16'hff22
`define ERR_ILLEGAL 16'hff20

// ==========================================================
// Buffer measurement type words, four ASCII characters
`define MT_WORD_PEAK 32'h5045414b
`define MT_WORD_RATIO 32'h50544156
`define MT_WORD_AVERAGE 32'h41564552
`define MT_WORD_MIN 32'h4d494e20

`endif

// File: settings_handler_pkg.sv
// Purpose: Types of the sensor channel settings handler.
// Assumes: Nothing else.
// Notes:   Constants live in settings_handler_regs.svh.
package settings_handler_pkg;

  // ========================================================
  // Attached sensor class
  typedef enum logic [1:0] {
    SENS_NONE,
    SENS_OTHER,
    SENS_BUF_ONLY,
    SENS_PEAK
  } sensor_t;

  // ========================================================
  // Video bandwidth choice
  typedef enum logic [1:0] {
    BW_OFF,
    BW_LOW,
    BW_BANDWIDTH_CHOICE_A,
    BW_HIGH
  } bw_t;

  // ========================================================
  // Buffer measurement type
  typedef enum logic [1:0] {
    MT_PEAK,
    MT_RATIO,
    MT_AVERAGE,
    MT_MIN
  } mtype_t;

endpackage

// File: sensor_channel_settings_handler.sv
// Purpose: Per-channel settings handler: video averaging, video
//          bandwidth, buffer size and type, gain correction.
// Assumes: Sensor and trigger status inputs come from logic on
//          clock_i, so they are read without synchronisers.
// Notes:   Errors are reported as a one-cycle pulse with a code.
// Behaviour
// - Video averaging enable, on at reset
// - Video commands on wrong sensor give -241
// - Video commands in averaging mode give -221
// - Four bandwidth choices, off at reset, queryable
// - Non-off bandwidth enables flattening, off none
// - Buffer size 1 to 2048, one at reset
// - Out-of-range size clipped, -222 names limit
// - Nonzero sweep step overrides buffer size
// - Size write during sweep gives -221
// - Size set with trace on reverts display
// - Buffer commands without suitable sensor give -241
// - Buffer commands in free-run give -221
// - Four buffer types, average at reset
// - Type in average mode or internal trigger -221
// - Unknown type string gives -224
// - Gain 1 to 150 percent, 100 at reset
// - Every result multiplied by gain over hundred
// - Both gain keywords behave identically
`timescale 1ns/10ps
`include "settings_handler_regs.svh"

module sensor_channel_settings_handler #(
  parameter int MEAS_W = 24,
  parameter int BUFSZ_MAX = `BUFSZ_MAX_DEF
) (
  input logic clock_i,
  input logic rstn_i,
  input logic ce_i,
  input logic [7:0] addr_i,
  input logic [31:0] wr_data_i,
  input logic wr_i,
  input logic rd_i,
  input settings_handler_pkg::sensor_t sensor_kind_i,
  input logic sensor_avg_mode_i,
  input logic free_run_i,
  input logic trig_external_i,
  input logic [11:0] sweep_step_count_i,
  input logic trace_on_i,
  input logic dual_chan_i,
  input logic [MEAS_W-1:0] meas_i,
  input logic meas_valid_i,
  output logic [31:0] rd_data_o,
  output logic err_valid_o,
  output logic [15:0] err_code_o,
  output logic err_upper_o,
  output logic video_averaging_enable_o,
  output settings_handler_pkg::bw_t video_bandwidth_select_o,
  output logic flatten_en_o,
  output logic [11:0] buf_size_o,
  output settings_handler_pkg::mtype_t buffer_measurement_type_o,
  output logic [7:0] gain_correction_factor_o,
  output logic revert_o,
  output logic revert_analog_o,
  output logic [MEAS_W:0] result_o,
  output logic result_valid_o
);

  // ========================================================
  // Elaboration checks
  // The buffer size field is twelve bits wide
  if (BUFSZ_MAX < 1 || BUFSZ_MAX > 4095) begin : g_bad_bufsz
    $error("BUFSZ_MAX must lie in 1..4095");
  end
  if (MEAS_W < 1 || MEAS_W > 48) begin : g_bad_meas
    $error("MEAS_W must lie in 1..48");
  end

  localparam logic [11:0] BUF_MAX = 12'(BUFSZ_MAX);

  // ========================================================
  // State
  typedef struct packed {
    logic vavg;
    settings_handler_pkg::bw_t bw;
    logic flatten;
    logic [11:0] buf_size;
    settings_handler_pkg::mtype_t mtype;
    logic [7:0] gain;
    logic [15:0] err_code;
    logic err_upper;
    logic err_sticky;
    logic err_pulse;
    logic revert;
    logic revert_analog;
    logic [31:0] rd_data;
    logic [MEAS_W:0] result;
    logic res_valid;
  } state_t;

  state_t st_ff;
  state_t nxt;

  logic err_set;
  logic [15:0] err_code;
  logic err_hi;
  logic vid_ok;
  logic buf_ok;
  logic [MEAS_W+7:0] prod;
  logic [MEAS_W+7:0] quot;

  // ========================================================
  // Next-state logic
  always_comb begin
    nxt = st_ff;
    nxt.rd_data = 32'h0;
    nxt.err_pulse = 1'b0;
    nxt.revert = 1'b0;
    nxt.res_valid = 1'b0;
    err_set = 1'b0;
    err_code = 16'h0000;
    err_hi = 1'b0;
    vid_ok = 1'b0;
    buf_ok = 1'b0;
    prod = {8'h00, meas_i} * {{MEAS_W{1'b0}}, st_ff.gain};
    quot = prod / {{MEAS_W{1'b0}}, `GAIN_SCALE};

    if (rd_i) begin
      case (addr_i)
        `ADR_VAVG: nxt.rd_data = {31'h0, st_ff.vavg};
        `ADR_VBW: nxt.rd_data = {30'h0, st_ff.bw};
        `ADR_BUFSZ: nxt.rd_data = {20'h0, st_ff.buf_size};
        `ADR_BUFTYPE: begin
          case (st_ff.mtype)
            settings_handler_pkg::MT_PEAK: nxt.rd_data = `MT_WORD_PEAK;
            settings_handler_pkg::MT_RATIO: nxt.rd_data = `MT_WORD_RATIO;
            settings_handler_pkg::MT_AVERAGE: nxt.rd_data = `MT_WORD_AVERAGE;
            default: nxt.rd_data = `MT_WORD_MIN;
          endcase
        end
        `ADR_GAIN, `ADR_GAIN_ALIAS: nxt.rd_data = {24'h0, st_ff.gain};
        `ADR_ERR: nxt.rd_data = {14'h0, st_ff.err_sticky,
                                 st_ff.err_upper, st_ff.err_code};
        `ADR_GAIN_MIN: nxt.rd_data = {24'h0, `GAIN_MIN};
        `ADR_GAIN_MAX: nxt.rd_data = {24'h0, `GAIN_MAX};
        default: nxt.rd_data = 32'h0;
      endcase
    end

    // sweep step count replaces buffer size, clamped to range
    if (sweep_step_count_i != 12'h000) begin
      if (sweep_step_count_i > BUF_MAX) begin
        nxt.buf_size = BUF_MAX;
      end else begin
        nxt.buf_size = sweep_step_count_i;
      end
    end

    // Clear of the sticky error; a same-cycle error sets it again
    if (wr_i && addr_i == `ADR_ERR) begin
      nxt.err_sticky = 1'b0;
    end

    if (wr_i) begin
      case (addr_i)
        `ADR_VAVG, `ADR_VBW: begin
          if (sensor_kind_i != settings_handler_pkg::SENS_PEAK) begin
            err_set = 1'b1;
            err_code = `ERR_HW_MISSING;
          end else if (sensor_avg_mode_i) begin
            err_set = 1'b1;
            err_code = `ERR_CONFLICT;
          end else begin
            vid_ok = 1'b1;
          end
          if (vid_ok && addr_i == `ADR_VAVG) begin
            nxt.vavg = wr_data_i[0];
          end
          if (vid_ok && addr_i == `ADR_VBW) begin
            if (wr_data_i[31:2] != 30'h0) begin
              err_set = 1'b1;
              err_code = `ERR_ILLEGAL;
            end else begin
              nxt.bw = settings_handler_pkg::bw_t'(wr_data_i[1:0]);
            end
          end
        end
        `ADR_BUFSZ: begin
          if (sensor_kind_i == settings_handler_pkg::SENS_NONE ||
              sensor_kind_i == settings_handler_pkg::SENS_OTHER) begin
            err_set = 1'b1;
            err_code = `ERR_HW_MISSING;
          end else if (free_run_i) begin
            err_set = 1'b1;
            err_code = `ERR_CONFLICT;
          end else if (sweep_step_count_i != 12'h000) begin
            err_set = 1'b1;
            err_code = `ERR_CONFLICT;
          end else begin
            buf_ok = 1'b1;
          end
          if (buf_ok) begin
            if ($signed(wr_data_i) < 32'sh1) begin
              nxt.buf_size = `BUFSZ_MIN;
              err_set = 1'b1;
              err_code = `ERR_RANGE;
            end else if (wr_data_i > {20'h0, BUF_MAX}) begin
              nxt.buf_size = BUF_MAX;
              err_set = 1'b1;
              err_code = `ERR_RANGE;
              err_hi = 1'b1;
            end else begin
              nxt.buf_size = wr_data_i[11:0];
            end
            if (trace_on_i) begin
              nxt.revert = 1'b1;
              nxt.revert_analog = ~dual_chan_i;
            end
          end
        end
        `ADR_BUFTYPE: begin
          if (sensor_kind_i != settings_handler_pkg::SENS_PEAK) begin
            err_set = 1'b1;
            err_code = `ERR_HW_MISSING;
          // acquisition, sensor mode or trigger conflict
          end else if (free_run_i || sensor_avg_mode_i ||
                       !trig_external_i) begin
            err_set = 1'b1;
            err_code = `ERR_CONFLICT;
          end else begin
            case (wr_data_i)
              `MT_WORD_PEAK: nxt.mtype = settings_handler_pkg::MT_PEAK;
              `MT_WORD_RATIO: nxt.mtype = settings_handler_pkg::MT_RATIO;
              `MT_WORD_AVERAGE: nxt.mtype = settings_handler_pkg::MT_AVERAGE;
              `MT_WORD_MIN: nxt.mtype = settings_handler_pkg::MT_MIN;
              default: begin
                err_set = 1'b1;
                err_code = `ERR_ILLEGAL;
              end
            endcase
          end
        end
        // both gain offsets share one path
        `ADR_GAIN, `ADR_GAIN_ALIAS: begin
          if ($signed(wr_data_i) < 32'sh1) begin
            nxt.gain = `GAIN_MIN;
            err_set = 1'b1;
            err_code = `ERR_RANGE;
          end else if (wr_data_i > {24'h0, `GAIN_MAX}) begin
            nxt.gain = `GAIN_MAX;
            err_set = 1'b1;
            err_code = `ERR_RANGE;
            err_hi = 1'b1;
          end else begin
            nxt.gain = wr_data_i[7:0];
          end
        end
        default: err_set = 1'b0;
      endcase
    end

    // Error report; set wins over a clear in the same cycle
    if (err_set) begin
      nxt.err_pulse = 1'b1;
      nxt.err_code = err_code;
      nxt.err_upper = err_hi;
      nxt.err_sticky = 1'b1;
    end

    nxt.flatten = (nxt.bw != settings_handler_pkg::BW_OFF);

    // scale each result by gain over one hundred
    if (meas_valid_i) begin
      nxt.result = quot[MEAS_W:0];
      nxt.res_valid = 1'b1;
    end
  end

  // ========================================================
  // State register; clock enable freezes everything
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
      st_ff.vavg <= `RST_VAVG;
      st_ff.bw <= settings_handler_pkg::BW_OFF;
      st_ff.buf_size <= `RST_BUFSZ;
      st_ff.mtype <= settings_handler_pkg::MT_AVERAGE;
      st_ff.gain <= `RST_GAIN;
    end else if (ce_i) begin
      st_ff <= nxt;
    end
  end

  // ========================================================
  // Outputs, all straight from the state register
  assign rd_data_o = st_ff.rd_data;
  assign err_valid_o = st_ff.err_pulse;
  assign err_code_o = st_ff.err_code;
  assign err_upper_o = st_ff.err_upper;
  assign video_averaging_enable_o = st_ff.vavg;
  assign video_bandwidth_select_o = st_ff.bw;
  assign flatten_en_o = st_ff.flatten;
  assign buf_size_o = st_ff.buf_size;
  assign buffer_measurement_type_o = st_ff.mtype;
  assign gain_correction_factor_o = st_ff.gain;
  assign revert_o = st_ff.revert;
  assign revert_analog_o = st_ff.revert_analog;
  assign result_o = st_ff.result;
  assign result_valid_o = st_ff.res_valid;

  // ========================================================
  // Assertions
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  // Accepted buffer size write conditions, written value not checked
  sequence s_buf_accept;
    ce_i && wr_i && addr_i == `ADR_BUFSZ &&
    sensor_kind_i inside {settings_handler_pkg::SENS_BUF_ONLY,
                          settings_handler_pkg::SENS_PEAK} &&
    !free_run_i && sweep_step_count_i == 12'h000;
  endsequence

  // Video write on a peak sensor in averaging mode
  sequence s_vid_conflict;
    ce_i && wr_i && addr_i inside {`ADR_VAVG, `ADR_VBW} &&
    sensor_kind_i == settings_handler_pkg::SENS_PEAK && sensor_avg_mode_i;
  endsequence

  a_vid_hw_missing: assert property (
    ce_i && wr_i && addr_i == `ADR_VAVG &&
    sensor_kind_i != settings_handler_pkg::SENS_PEAK
    |=> err_valid_o && err_code_o == `ERR_HW_MISSING &&
        $stable(video_averaging_enable_o))
    else $error("video averaging write not refused on wrong sensor");

  a_vid_conflict: assert property (
    s_vid_conflict |=> err_valid_o && err_code_o == `ERR_CONFLICT &&
                       $stable(video_bandwidth_select_o))
    else $error("video conflict not reported");

  a_flatten_bw: assert property (
    ce_i && wr_i && addr_i == `ADR_VBW &&
    sensor_kind_i == settings_handler_pkg::SENS_PEAK && !sensor_avg_mode_i &&
    wr_data_i[31:2] == 30'h0
    |=> video_bandwidth_select_o == $past(wr_data_i[1:0]) &&
        flatten_en_o == ($past(wr_data_i[1:0]) != 2'b00))
    else $error("flattening does not follow bandwidth");

  a_buf_clip_hi: assert property (
    s_buf_accept ##0 ($signed(wr_data_i) > 32'sh800)
    |=> buf_size_o == 12'h800 && err_valid_o &&
        err_code_o == `ERR_RANGE && err_upper_o)
    else $error("buffer size not clipped to upper limit");

  a_buf_sweep: assert property (
    ce_i && sweep_step_count_i != 12'h000 &&
    sweep_step_count_i <= 12'h800
    |=> buf_size_o == $past(sweep_step_count_i))
    else $error("sweep step count did not override buffer size");

  a_buf_sweep_err: assert property (
    ce_i && wr_i && addr_i == `ADR_BUFSZ &&
    sensor_kind_i == settings_handler_pkg::SENS_PEAK && !free_run_i &&
    sweep_step_count_i != 12'h000
    |=> err_valid_o && err_code_o == `ERR_CONFLICT)
    else $error("buffer write during sweep not refused");

  // display reverts one cycle later, then drops
  a_trace_revert: assert property (
    s_buf_accept ##0 trace_on_i
    |=> revert_o && revert_analog_o == !$past(dual_chan_i)
    ##1 (!revert_o || !$past(ce_i) || $past(wr_i)))
    else $error("trace display did not revert");

  a_mtype_bad: assert property (
    ce_i && wr_i && addr_i == `ADR_BUFTYPE &&
    sensor_kind_i == settings_handler_pkg::SENS_PEAK && !free_run_i &&
    !sensor_avg_mode_i && trig_external_i &&
    !(wr_data_i inside {`MT_WORD_PEAK, `MT_WORD_RATIO,
                        `MT_WORD_AVERAGE, `MT_WORD_MIN})
    |=> err_valid_o && err_code_o == `ERR_ILLEGAL &&
        $stable(buffer_measurement_type_o))
    else $error("illegal buffer type not refused");

  a_gain_result: assert property (
    ce_i && meas_valid_i
    |=> result_valid_o && 56'(result_o) ==
        (56'($past(meas_i)) * 56'($past(gain_correction_factor_o))) /
        56'd100)
    else $error("result not scaled by gain");

  a_query_stable: assert property (
    ce_i && rd_i && !wr_i
    |=> $stable(video_averaging_enable_o) &&
        $stable(video_bandwidth_select_o) &&
        $stable(gain_correction_factor_o) &&
        $stable(buffer_measurement_type_o))
    else $error("query changed a setting");

endmodule // sensor_channel_settings_handler

// File: sensor_side_model.sv
// Purpose: Far-side model: attached sensor status and measurements.
// Assumes: The bench changes the profile right after a clock edge.
// Notes:   Status follows the profile at once, with no pipeline, so
//          the handler sees a new profile at the next edge.
`timescale 1ns/10ps

module sensor_side_model (
  input wire logic [2:0] profile_i,
  input wire logic fire_i,
  input wire logic dual_i,
  input wire logic [23:0] value_i,
  output settings_handler_pkg::sensor_t sensor_kind_o,
  output logic avg_mode_o,
  output logic free_run_o,
  output logic trig_external_o,
  output logic [11:0] sweep_o,
  output logic trace_o,
  output logic dual_o,
  output logic [23:0] meas_o,
  output logic meas_valid_o
);

  // ========================================================
  // Status profiles, each breaks one condition of profile 0
  always_comb begin
    sensor_kind_o = settings_handler_pkg::SENS_PEAK;
    avg_mode_o = 1'b0;
    free_run_o = 1'b0;
    trig_external_o = 1'b1;
    sweep_o = 12'h000;
    trace_o = 1'b0;
    // Channel count is set by the bench on its own
    dual_o = dual_i;
    case (profile_i)
      3'h1: sensor_kind_o = settings_handler_pkg::SENS_OTHER;
      3'h2: avg_mode_o = 1'b1;
      3'h3: sensor_kind_o = settings_handler_pkg::SENS_NONE;
      3'h4: free_run_o = 1'b1;
      3'h5: trig_external_o = 1'b0;
      3'h6: sweep_o = 12'h032;
      3'h7: trace_o = 1'b1;
      default: ;
    endcase
  end

  // ========================================================
  // Idle data shows the inverse, so a stale value never passes
  assign meas_o = fire_i ? value_i : ~value_i;
  assign meas_valid_o = fire_i;

endmodule // sensor_side_model

// File: sensor_channel_settings_handler_tb_top.sv
// Purpose: Self-checking bench of the sensor channel settings handler.
// Assumes: Every access takes two cycles; no back-to-back traffic.
// Notes:   Prints only mismatches and the verdict.
`timescale 1ns/10ps
`include "settings_handler_regs.svh"

module sensor_channel_settings_handler_tb_top;
  logic clock_i, rstn_i, ce_i, wr_i, rd_i, fire;
  logic [7:0] addr_i;
  logic [31:0] wr_data_i, rd_data_o;
  logic [2:0] prof;
  logic [23:0] mval, meas;
  settings_handler_pkg::sensor_t kind;
  settings_handler_pkg::bw_t bw;
  settings_handler_pkg::mtype_t mt;
  logic avgm, frun, trig, trace, dual, mv, err_valid_o, err_upper_o, two_ch;
  logic vavg, flat, revert, revert_an, res_v, ev, eu, rv, ra;
  logic [11:0] sweep, bsz;
  logic [15:0] err_code_o, ec;
  logic [7:0] gain;
  logic [24:0] res;
  logic [31:0] words [4];
  int fails, num_checks;

  // ========================================================
  // Clock, far side and design
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  sensor_side_model partner (.profile_i(prof), .fire_i(fire),
    .value_i(mval), .dual_i(two_ch), .sensor_kind_o(kind),
    .avg_mode_o(avgm), .free_run_o(frun), .trig_external_o(trig),
    .sweep_o(sweep),
    .trace_o(trace), .dual_o(dual), .meas_o(meas), .meas_valid_o(mv));

  sensor_channel_settings_handler DUT (.clock_i(clock_i),
    .rstn_i(rstn_i), .ce_i(ce_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .sensor_kind_i(kind), .sensor_avg_mode_i(avgm),
    .free_run_i(frun), .trig_external_i(trig),
    .sweep_step_count_i(sweep), .trace_on_i(trace),
    .dual_chan_i(dual), .meas_i(meas), .meas_valid_i(mv),
    .rd_data_o(rd_data_o), .err_valid_o(err_valid_o),
    .err_code_o(err_code_o), .err_upper_o(err_upper_o),
    .video_averaging_enable_o(vavg), .video_bandwidth_select_o(bw),
    .flatten_en_o(flat), .buf_size_o(bsz),
    .buffer_measurement_type_o(mt), .gain_correction_factor_o(gain),
    .revert_o(revert), .revert_analog_o(revert_an),
    .result_o(res), .result_valid_o(res_v));

  // ========================================================
  // Access tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Pulse results are captured in the answer cycle, their only one
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    #1;
    ev = err_valid_o;
    ec = err_code_o;
    eu = err_upper_o;
    rv = revert;
    ra = revert_an;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    chk(rd_data_o, exp);
  endtask

  task err(input logic [15:0] code);
    chk({31'h0, ev}, 32'h1);
    chk({16'h0, ec}, {16'h0, code});
  endtask

  task env(input logic [2:0] p);
    @(posedge clock_i);
    prof <= p;
  endtask

  task meas_chk(input logic [23:0] v, input logic [31:0] exp);
    @(posedge clock_i);
    fire <= 1'b1;
    mval <= v;
    @(posedge clock_i);
    fire <= 1'b0;
    #1;
    chk({31'h0, res_v}, 32'h1);
    chk({7'h0, res}, exp);
  endtask

  task test_done;
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ========================================================
  // Watchdog, far beyond the under two hundred cycles of the tests
  initial begin
    repeat (5000) @(posedge clock_i);
    fails++;
    test_done();
  end

  // ========================================================
  // Main sequence
  initial begin
    words = '{`MT_WORD_PEAK, `MT_WORD_RATIO, `MT_WORD_AVERAGE,
              `MT_WORD_MIN};
    {rstn_i, wr_i, rd_i, fire, two_ch, addr_i, wr_data_i} = '0;
    ce_i = 1'b1;
    prof = 3'h0;
    mval = 24'h000000;
    repeat (10) @(posedge clock_i);
    rstn_i <= 1'b1;
    // Reset values, averaging read twice to show reads change nothing
    rd(`ADR_VAVG, 32'h1);
    rd(`ADR_VAVG, 32'h1);
    rd(`ADR_VBW, 32'h0);
    rd(`ADR_BUFSZ, 32'h1);
    rd(`ADR_BUFTYPE, `MT_WORD_AVERAGE);
    rd(`ADR_GAIN, 32'h64);
    rd(`ADR_GAIN_MIN, 32'h1);
    rd(`ADR_GAIN_MAX, 32'h96);
    // Video commands refused by sensor kind and mode
    env(3'h1);
    wr(`ADR_VAVG, 32'h0);
    err(`ERR_HW_MISSING);
    wr(`ADR_VBW, 32'h3);
    err(`ERR_HW_MISSING);
    env(3'h2);
    wr(`ADR_VAVG, 32'h0);
    err(`ERR_CONFLICT);
    wr(`ADR_VBW, 32'h2);
    err(`ERR_CONFLICT);
    rd(`ADR_VAVG, 32'h1);
    env(3'h0);
    wr(`ADR_VAVG, 32'h0);
    rd(`ADR_VAVG, 32'h0);
    chk({31'h0, vavg}, 32'h0);
    // Writes are ignored while the clock enable is low
    @(posedge clock_i);
    ce_i <= 1'b0;
    wr(`ADR_VAVG, 32'h1);
    chk({31'h0, vavg}, 32'h0);
    chk({31'h0, ev}, 32'h0);
    @(posedge clock_i);
    ce_i <= 1'b1;
    rd(`ADR_VAVG, 32'h0);
    // Every bandwidth choice, flattening on all but off
    for (int i = 3; i >= 0; i--) begin
      wr(`ADR_VBW, 32'(i));
      chk({31'h0, ev}, 32'h0);
      rd(`ADR_VBW, 32'(i));
      chk({30'h0, bw}, 32'(i));
      chk({31'h0, flat}, {31'h0, i != 0});
    end
    // Buffer size clipping at both limits
    wr(`ADR_BUFSZ, 32'h0);
    err(`ERR_RANGE);
    chk({31'h0, eu}, 32'h0);
    rd(`ADR_BUFSZ, 32'h1);
    wr(`ADR_BUFSZ, 32'h1388);
    err(`ERR_RANGE);
    chk({31'h0, eu}, 32'h1);
    rd(`ADR_BUFSZ, 32'h800);
    wr(`ADR_BUFSZ, 32'h64);
    rd(`ADR_BUFSZ, 32'h64);
    chk({20'h0, bsz}, 32'h64);
    chk({31'h0, rv}, 32'h0);
    env(3'h7);
    wr(`ADR_BUFSZ, 32'hc8);
    chk({30'h0, rv, ra}, 32'h3);
    // Two channels revert to the numeric form
    @(posedge clock_i);
    two_ch <= 1'b1;
    wr(`ADR_BUFSZ, 32'hc9);
    chk({30'h0, rv, ra}, 32'h2);
    // Sweep owns the buffer size
    env(3'h6);
    wr(`ADR_BUFSZ, 32'h7);
    err(`ERR_CONFLICT);
    rd(`ADR_BUFSZ, 32'h32);
    // Missing sensor, free run
    env(3'h3);
    wr(`ADR_BUFSZ, 32'h5);
    err(`ERR_HW_MISSING);
    wr(`ADR_BUFTYPE, `MT_WORD_PEAK);
    err(`ERR_HW_MISSING);
    env(3'h4);
    wr(`ADR_BUFSZ, 32'h5);
    err(`ERR_CONFLICT);
    wr(`ADR_BUFTYPE, `MT_WORD_PEAK);
    err(`ERR_CONFLICT);
    // Every buffer type, then refusals
    env(3'h0);
    for (int i = 0; i < 4; i++) begin
      wr(`ADR_BUFTYPE, words[i]);
      rd(`ADR_BUFTYPE, words[i]);
      chk({30'h0, mt}, 32'(i));
    end
    wr(`ADR_BUFTYPE, 32'h41424344);
    err(`ERR_ILLEGAL);
    env(3'h5);
    wr(`ADR_BUFTYPE, `MT_WORD_PEAK);
    err(`ERR_CONFLICT);
    env(3'h2);
    wr(`ADR_BUFTYPE, `MT_WORD_PEAK);
    err(`ERR_CONFLICT);
    rd(`ADR_BUFTYPE, `MT_WORD_MIN);
    // Gain limits, both keywords, scaling with truncation
    env(3'h0);
    wr(`ADR_GAIN, 32'h0);
    err(`ERR_RANGE);
    rd(`ADR_GAIN, 32'h1);
    wr(`ADR_GAIN, 32'hc8);
    err(`ERR_RANGE);
    rd(`ADR_GAIN, 32'h96);
    // Error word holds code, upper flag and sticky flag
    rd(`ADR_ERR, 32'h0003ff22);
    wr(`ADR_ERR, 32'h0);
    rd(`ADR_ERR, 32'h0001ff22);
    wr(`ADR_GAIN_ALIAS, 32'h25);
    rd(`ADR_GAIN, 32'h25);
    chk({24'h0, gain}, 32'h25);
    meas_chk(24'h0003e7, 32'h171);
    wr(`ADR_GAIN, 32'h96);
    rd(`ADR_GAIN_ALIAS, 32'h96);
    meas_chk(24'h0003e8, 32'h5dc);
    // Unmapped place reads zero and raises nothing
    rd(8'h40, 32'h0);
    wr(8'h40, 32'h1);
    chk({31'h0, ev}, 32'h0);
    // Reset in mid-run brings every changed setting back
    @(posedge clock_i);
    rstn_i <= 1'b0;
    @(posedge clock_i);
    rstn_i <= 1'b1;
    rd(`ADR_VAVG, 32'h1);
    rd(`ADR_BUFTYPE, `MT_WORD_AVERAGE);
    rd(`ADR_GAIN, 32'h64);
    chk({20'h0, bsz}, 32'h1);
    chk({24'h0, gain}, 32'h64);
    test_done();
  end

endmodule // sensor_channel_settings_handler_tb_top
